// ===== hdl/epc_ctrl.sv
// What this block does
// RULE1: unprogrammed or erased array bytes read as zero
// RULE2: valid array addresses are be00-fdff and ffd2-ffff
// RULE3: array holds sixteen kilobytes, erasable only in the windowed part
// RULE4: latch bit set reconfigures buses and blocks array reads
// RULE5: writing latch bit clear also clears voltage bit
// RULE6: voltage bit can be set only if latch bit already set
// RULE7: every reset clears the voltage bit
// RULE8: one write setting both bits sets only the latch bit
// RULE9: with latch on, only writes to valid addresses are captured
// RULE10: invalid latched address never gets programming voltage
// RULE11: with latch on, reads of valid addresses return the captured byte
// RULE12: after first captured write, further valid writes are ignored
// RULE13: supply reaches array only with voltage bit and valid capture
// RULE14: clearing voltage bit removes supply at once
// RULE15: programming only turns zeros into ones
// RULE16: software raises supply, latches, writes, enables, waits, clears
// RULE17: a protection lock prevents outside viewing of contents
// RULE18: latch bit resets clear so buses start in normal mode
`default_nettype none
module epc_ctrl
  import epc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        outside_view,
  input  wire logic        supply_high,
  output logic [7:0]       rdata,
  output logic             program_supply_on,
  output logic             program_latch_enable,
  output logic             program_voltage_enable
);
  logic [7:0]  mem [0:EPC_CAP_BYTES-1];
  logic        valid;
  logic [13:0] index;
  logic [13:0] cap_index;
  epc_latch_s  cap;
  epc_latch_s  next_cap;
  logic        captured;
  logic        next_captured;
  logic        lat;
  logic        next_lat;
  logic        pgm;
  logic        next_pgm;
  logic        lock;
  logic        next_lock;
  logic [7:0]  next_rdata;
  logic        next_supply;

  epc_range u_range (
    .addr  (addr),
    .valid (valid),
    .index (index)
  );

  epc_range u_cap_range (
    .addr  (cap.addr),
    .valid (),
    .index (cap_index)
  );

  always_comb begin
    next_lat      = lat;
    next_pgm      = pgm;
    next_lock     = lock;
    next_cap      = cap;
    next_captured = captured;
    if (wr && addr == EPC_CTRL_ADDR) begin
      next_lat = wdata[EPC_LAT_BIT];
      if (!wdata[EPC_LAT_BIT]) begin
        next_pgm      = 1'b0;                                  // [RULE5]
        next_captured = 1'b0;
      end else if (lat) begin
        next_pgm = wdata[EPC_PGM_BIT];                         // [RULE6] [RULE8]
      end
      // lock is sticky until reset
      if (wdata[EPC_LOCK_BIT]) begin
        next_lock = 1'b1;                                      // [RULE17]
      end
    end else if (wr && lat && valid && !captured) begin
      next_cap.addr = addr;                                    // [RULE9]
      next_cap.data = wdata;
      next_captured = 1'b1;                                    // [RULE12]
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      if (addr == EPC_CTRL_ADDR) begin
        next_rdata[EPC_LAT_BIT]  = lat;
        next_rdata[EPC_PGM_BIT]  = pgm;
        next_rdata[EPC_LOCK_BIT] = lock;
      end else if (valid && lat) begin
        next_rdata = captured ? cap.data : EPC_BLANK;          // [RULE4] [RULE11]
      end else if (valid && !(lock && outside_view)) begin
        next_rdata = mem[index];                               // [RULE1] [RULE2] [RULE17]
      end
    end
    // supply only with a valid capture; invalid writes never capture
    next_supply = next_pgm && next_captured && supply_high;    // [RULE10] [RULE13] [RULE14]
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      lat         <= 1'b0;                                     // [RULE18]
      pgm         <= 1'b0;                                     // [RULE7]
      lock        <= 1'b0;
      captured    <= 1'b0;
      cap         <= '0;
      rdata       <= 8'h00;
      program_supply_on <= 1'b0;
    end else begin
      lat         <= next_lat;
      pgm         <= next_pgm;
      lock        <= next_lock;
      captured    <= next_captured;
      cap         <= next_cap;
      rdata       <= next_rdata;
      program_supply_on <= next_supply;
    end
  end

  // array starts blank; erase happens outside this logic
  initial begin
    for (int i = 0; i < EPC_CAP_BYTES; i++) begin
      mem[i] = EPC_BLANK;                                      // [RULE1]
    end
  end

  always_ff @(posedge clock) begin
    if (program_supply_on) begin
      mem[cap_index] <= mem[cap_index] | cap.data;             // [RULE3] [RULE15]
    end
  end

  assign program_latch_enable   = lat;
  assign program_voltage_enable = pgm;
endmodule // epc_ctrl
`default_nettype wire

// ===== hdl/epc_pkg.sv
`default_nettype none
package epc_pkg;
  localparam logic [15:0] EPC_CTRL_ADDR   = 16'h001f;
  localparam logic [15:0] EPC_MAIN_LO     = 16'hbe00;
  localparam logic [15:0] EPC_MAIN_HI     = 16'hfdff;
  localparam logic [15:0] EPC_VEC_LO      = 16'hffd2;
  localparam logic [15:0] EPC_VEC_HI      = 16'hffff;
  localparam int          EPC_CAP_BYTES   = 16384;
  localparam logic [7:0]  EPC_BLANK       = 8'h00;
  localparam int          EPC_LAT_BIT     = 0;
  localparam int          EPC_PGM_BIT     = 1;
  localparam int          EPC_LOCK_BIT    = 7;
  localparam logic [7:0]  EPC_CTRL_RESET  = 8'h00;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } epc_latch_s;
endpackage
`default_nettype wire

// ===== hdl/epc_range.sv
`default_nettype none
module epc_range
  import epc_pkg::*;
(
  input  wire logic [15:0] addr,
  output logic             valid,
  output logic [13:0]      index
);
  logic in_main;
  logic in_vec;
  logic [15:0] off;
  assign in_main = (addr >= EPC_MAIN_LO) && (addr <= EPC_MAIN_HI);
  assign in_vec  = (addr >= EPC_VEC_LO) && (addr <= EPC_VEC_HI);
  assign valid   = in_main || in_vec;
  // main range fills all 16k; vector bytes wrap onto the lowest indices (aliasing)
  always_comb begin
    if (in_main) begin
      off = addr - EPC_MAIN_LO;
    end else begin
      off = addr - EPC_VEC_LO + (EPC_MAIN_HI - EPC_MAIN_LO + 16'h0001);
    end
  end
  assign index = off[13:0];
endmodule // epc_range

// ===== tb/epc_checker.sv
`default_nettype none
module epc_checker
  import epc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        program_supply_on,
  input wire logic        program_latch_enable,
  input wire logic        program_voltage_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire l = program_latch_enable;
  wire v = program_voltage_enable;
  wire s = program_supply_on;
  wire cw = wr && addr == EPC_CTRL_ADDR;
  property p_rst; disable iff (1'b0) !rst_b |=> !v && !l && !s; endproperty
  a_rst: assert property (p_rst) else $error("bits survive reset");
  property p_clr; cw && !wdata[0] |=> !v; endproperty
  a_clr: assert property (p_clr) else $error("voltage kept");
  property p_six; cw && !l |=> !v; endproperty
  a_six: assert property (p_six) else $error("voltage set early");
  property p_set; cw && l && wdata[1] && wdata[0] |=> v; endproperty
  a_set: assert property (p_set) else $error("voltage not set");
  property p_lat; cw |=> l == $past(wdata[0]); endproperty
  a_lat: assert property (p_lat) else $error("latch bit wrong");
  property p_sup; s |-> v && l; endproperty
  a_sup: assert property (p_sup) else $error("supply without bits");
  property p_off; cw && !wdata[1] |=> !s; endproperty
  a_off: assert property (p_off) else $error("supply kept");
  property p_hold; !wr |=> $stable(v); endproperty
  a_hold: assert property (p_hold) else $error("voltage moved");
  c_prog: cover property (cw && l && wdata[1] ##1 s);
  c_rd: cover property (rd && l);
  c_rst: cover property (disable iff (1'b0) v ##1 !rst_b);
endmodule // epc_checker
bind epc_ctrl epc_checker epc_checker_i (.*);
`default_nettype wire

// ===== tb/epc_cpu.sv
`default_nettype none
module epc_cpu (
  input  wire logic        clock,
  output logic [15:0]      addr,
  output logic [7:0]       wdata,
  output logic             wr,
  output logic             rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr, wdata, wr, rd} = '0;
  // one-cycle strobe; bus scrambled after release so stale values never match
  task cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    {addr, wdata, wr, rd} <= {a, d, w, !w};
    @(posedge clock);
    {addr, wdata, wr, rd} <= {~a, ~d, 2'b00};
  endtask
endmodule // epc_cpu
`default_nettype wire

// ===== tb/tb_epc_ctrl.sv
`default_nettype none
module tb_epc_ctrl
  import epc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0, rst_b = 0, ov = 0, sh = 1, rd_q = 0;
  logic [15:0] addr, c = EPC_CTRL_ADDR;
  logic [7:0]  wdata, rdata, d;
  logic        wr, rd, sup, lat, pve;
  logic [31:0] s = 32'hf4db074f;
  logic [7:0]  q[$];
  int          n_errors = 0, samples_checked = 0;
  always #50 clock = ~clock;
  epc_cpu epc_cpu_i (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  epc_ctrl epc_ctrl_i (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .outside_view(ov), .supply_high(sh), .rdata(rdata), .program_supply_on(sup),
    .program_latch_enable(lat), .program_voltage_enable(pve));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task st(input logic [2:0] e);
    @(negedge clock);
    chk({5'h00, sup, pve, lat}, {5'h00, e});
  endtask
  task rq(input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    epc_cpu_i.cyc(1'b0, a, 8'h00);
  endtask
  task stop_test;
    if (q.size() != 0) n_errors++;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_q) chk(rdata, q.pop_front());
    rd_q <= rd;
  end
  initial begin
    s = xs(s);
    d = s[7:0] | 8'h01;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    st(3'h0);
    rq(EPC_MAIN_HI, 8'h00);
    epc_cpu_i.cyc(1'b1, c, 8'h03);
    st(3'h1);
    rq(c, 8'h01);
    rq(EPC_MAIN_LO, 8'h00);
    epc_cpu_i.cyc(1'b1, 16'h1000, d);
    rq(EPC_VEC_HI, 8'h00);
    epc_cpu_i.cyc(1'b1, EPC_MAIN_HI, d);
    epc_cpu_i.cyc(1'b1, EPC_VEC_LO, ~d);
    rq(EPC_MAIN_LO, d);
    rq(EPC_VEC_LO, d);
    epc_cpu_i.cyc(1'b1, c, 8'h03);
    st(3'h7);
    epc_cpu_i.cyc(1'b1, c, 8'h01);
    st(3'h1);
    epc_cpu_i.cyc(1'b1, c, 8'h00);
    st(3'h0);
    rq(EPC_MAIN_HI, d);
    epc_cpu_i.cyc(1'b1, c, 8'h02);
    st(3'h0);
    epc_cpu_i.cyc(1'b1, c, 8'h01);
    epc_cpu_i.cyc(1'b1, 16'hfe10, d);
    epc_cpu_i.cyc(1'b1, c, 8'h03);
    st(3'h3);
    epc_cpu_i.cyc(1'b1, c, 8'h01);
    epc_cpu_i.cyc(1'b1, EPC_MAIN_LO, d);
    sh <= 1'b0;
    epc_cpu_i.cyc(1'b1, c, 8'h03);
    st(3'h3);
    sh <= 1'b1;
    epc_cpu_i.cyc(1'b1, c, 8'h80);
    ov <= 1'b1;
    rq(EPC_MAIN_HI, 8'h00);
    ov <= 1'b0;
    rq(EPC_MAIN_HI, d);
    @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    st(3'h0);
    stop_test();
  end
endmodule // tb_epc_ctrl
`default_nettype wire
